// *** rtl/dcm_pkg.sv ***
// Purpose: shared constants and types for the data cache mode and snoop controller
// Assumes: 32-bit physical addresses, 16-byte lines of four long words
// Notes: register offsets are byte addresses on the apb slave
package dcm_pkg;

	// line geometry
	localparam int IDX_W = 6;
	localparam int TAG_W = 32 - 4 - IDX_W;
	localparam int LINE_W = 128;
	localparam int ENT_W = 1 + 4 + TAG_W + LINE_W;
	localparam logic [1:0] LAST_BEAT = 2'h3;

	// caching mode codes from translation
	localparam logic [1:0] MODE_WT = 2'h0;
	localparam logic [1:0] MODE_CB = 2'h1;
	localparam logic [1:0] MODE_NS = 2'h2;
	localparam logic [1:0] MODE_SER = 2'h3;

	// snoop control codes
	localparam logic [1:0] SNP_INHIBIT = 2'h0;
	localparam logic [1:0] SNP_KEEP_SINK = 2'h1;
	localparam logic [1:0] SNP_INVALID = 2'h2;
	localparam logic [1:0] SNP_RESERVED = 2'h3;

	// apb register map
	localparam logic [11:0] CTRL_OFF = 12'h000;
	localparam logic [11:0] STAT_OFF = 12'h004;
	localparam logic CTRL_EN_RST = 1'b0;
	localparam int CTRL_EN_BIT = 0;

	// one cache entry
	typedef struct packed {
		logic valid;
		logic [3:0] dirty;
		logic [TAG_W-1:0] tag;
		logic [LINE_W-1:0] data;
	} dcm_entry_s;

	typedef enum logic [2:0] {
		S_IDLE,
		S_CPU_LOOK,
		S_SNP_LOOK,
		S_SINGLE,
		S_FILL,
		S_PUSH
	} dcm_state_e;

endpackage : dcm_pkg

// *** rtl/dcm_line_ram.sv ***
// Purpose: line array holding tag, state and data of every set
// Assumes: one write port and one read port on sys_clk
// Notes: read data is registered, so it trails the read index by one cycle
`timescale 1ns/1ps
module dcm_line_ram #(
	parameter int WIDTH = dcm_pkg::ENT_W,
	parameter int IDXW = dcm_pkg::IDX_W
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// write port
	input wire logic wrEn,
	input wire logic [IDXW-1:0] wrIdx,
	input wire logic [WIDTH-1:0] wrData,
	// read port
	input wire logic [IDXW-1:0] rdIdx,
	output logic [WIDTH-1:0] rdData
);

	logic [WIDTH-1:0] mem [0:(1<<IDXW)-1];

	always_ff @(posedge sys_clk) begin
		if (wrEn) begin
			mem[wrIdx] <= wrData;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rdData <= '0;
		end else begin
			rdData <= mem[rdIdx];
		end
	end

endmodule : dcm_line_ram

// *** rtl/dcm_cache_ctrl.sv ***
// Purpose: data cache policy logic for processor and snooped accesses
// Assumes: requests held until acknowledged; memory bus answers each beat with busAck
// Notes: direct mapped array; one processor access in flight, served in order
// Behaviour
// (RQ1) write-through writes go to memory, update hits, never allocate on miss
// (RQ2) cachable read miss fetches line, returns data, installs line valid
// (RQ3) copyback write hit updates line, sets dirty bits, no bus access
// (RQ4) dirty data leaves only on replacement, inhibited match, or push instruction
// (RQ5) copyback write miss fills line first, then merges data and sets dirty
// (RQ6) dirty victim goes to copyback buffer, fill first, then buffer written out
// (RQ7) inhibited pages bypass cache with cache_inhibit_out high during transfer
// (RQ8) inhibited access matching a line pushes it if dirty, else invalidates
// (RQ9) serialized accesses run in order, operand read performed only once
// (RQ10) nonserialized reads may pass earlier writes and be re-read on restart
// (RQ11) exception and table-search misses do not allocate; hits act normally
// (RQ12) block move never allocates; read hits served; write hits invalidate and write
// (RQ13) after locked hit while disabled, first non-locked miss after enable uncached
// (RQ14) only snoopable transfers change state; snoop misses leave cache alone
// (RQ15) read hit: no bus, no state change; address bit 3 picks half-line
// (RQ16) snooped read on valid ignored; on dirty inhibit memory and supply line
// (RQ17) snooped read hit keeps state unless mark-invalid, then invalidates
// (RQ18) alternate master uses mark-invalid reads only for full line reads
// (RQ19) write-through write hit updates words, writes memory, keeps line state
// (RQ20) snooped line write on valid line, or mark-invalid write hit, invalidates
// (RQ21) sink write hitting dirty line inhibits memory, stores word, sets dirty
// (RQ22) alternate master: invalidate for write-through pages, sink for copyback
// (RQ23) snoop code 00 inhibit, 01 keep or sink, 10 invalidate, 11 inhibited
// (RQ24) line invalid, valid with clean dirty bits, or dirty with any dirty bit
// (RQ25) snoop requests take the array before processor requests
// (RQ26) caching mode input selects write-through, copyback, nonserialized, serialized
`timescale 1ns/1ps
module dcm_cache_ctrl (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// integer unit request
	input wire logic cpuReq,
	input wire logic cpuWr,
	input wire logic [31:0] cpuAddr,
	input wire logic [31:0] cpuWdata,
	input wire logic [1:0] cachingModeField,
	input wire logic cpuNoAlloc,
	input wire logic cpuBlockMove,
	input wire logic cpuLocked,
	output logic cpuAck,
	output logic [31:0] cpuRdata,
	// external memory bus master
	output logic busReq,
	output logic busWr,
	output logic busLine,
	output logic [31:0] busAddr,
	output logic [31:0] busWdata,
	output logic cacheInhibitOut,
	input wire logic busAck,
	input wire logic [31:0] busRdata,
	// snoop port from alternate masters
	input wire logic snpValid,
	input wire logic snpWr,
	input wire logic snpLine,
	input wire logic [1:0] snoopControl,
	input wire logic [31:0] snpAddr,
	input wire logic [31:0] snpWdata,
	output logic snpDone,
	output logic snpInhibitMem,
	output logic [127:0] snpRdata
);

	typedef struct packed {
		dcm_pkg::dcm_state_e st;
		logic ctrlEn;
		logic lockHit;
		logic skipNext;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic cpuAck;
		logic [31:0] cpuRdata;
		logic busReq;
		logic busWr;
		logic busLine;
		logic busCi;
		logic [31:0] busAddr;
		logic [31:0] busWdata;
		logic snpDone;
		logic snpInh;
		logic [127:0] snpRdata;
		logic [1:0] beat;
		logic [127:0] fillData;
		logic [127:0] cbData;
		logic [31:0] cbAddr;
		logic pushPend;
		logic singleAfter;
		logic arrWe;
		logic [dcm_pkg::IDX_W-1:0] arrIdx;
		dcm_pkg::dcm_entry_s arrWdata;
	} dcm_state_s;

	dcm_state_s cur_ff;
	dcm_state_s nxt_st;
	dcm_pkg::dcm_entry_s rdEnt;
	logic [dcm_pkg::IDX_W-1:0] rdIdx;
	logic [dcm_pkg::ENT_W-1:0] rdRaw;

	// snoops own the array read port while pending
	always_comb begin
		if (snpValid && !cur_ff.snpDone) begin // [RQ25]
			rdIdx = snpAddr[dcm_pkg::IDX_W+3:4];
		end else begin
			rdIdx = cpuAddr[dcm_pkg::IDX_W+3:4];
		end
	end

	dcm_line_ram #(
		.WIDTH(dcm_pkg::ENT_W),
		.IDXW(dcm_pkg::IDX_W)
	) u_ram (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.wrEn(cur_ff.arrWe),
		.wrIdx(cur_ff.arrIdx),
		.wrData(cur_ff.arrWdata),
		.rdIdx(rdIdx),
		.rdData(rdRaw)
	);

	assign rdEnt = dcm_pkg::dcm_entry_s'(rdRaw);

	always_comb begin
		dcm_state_s n;
		dcm_pkg::dcm_entry_s e;
		logic hit;
		logic dirty;
		logic inh;
		logic noAlloc;
		logic [1:0] w;
		logic [127:0] fd;
		n = cur_ff;
		e = rdEnt;
		hit = 1'b0;
		dirty = |rdEnt.dirty; // [RQ24]
		inh = 1'b0;
		noAlloc = 1'b0;
		w = cpuAddr[3:2];
		fd = cur_ff.fillData;
		n.cpuAck = 1'b0;
		n.snpDone = 1'b0;
		n.snpInh = 1'b0;
		n.arrWe = 1'b0;
		n.pready = 1'b0;
		n.pslverr = 1'b0;

		// apb: answer on the second access cycle, commit on the edge pready is seen
		if (psel && penable && !cur_ff.pready) begin
			n.pready = 1'b1;
			if (paddr == dcm_pkg::CTRL_OFF) begin
				n.prdata = {31'h0, cur_ff.ctrlEn};
			end else if (paddr == dcm_pkg::STAT_OFF) begin
				n.prdata = {28'h0, cur_ff.st != dcm_pkg::S_IDLE, cur_ff.pushPend,
					cur_ff.skipNext, cur_ff.lockHit};
			end else begin
				n.prdata = 32'h0;
				n.pslverr = 1'b1;
			end
		end
		if (psel && penable && cur_ff.pready && pwrite && paddr == dcm_pkg::CTRL_OFF) begin
			n.ctrlEn = pwdata[dcm_pkg::CTRL_EN_BIT];
			if (pwdata[dcm_pkg::CTRL_EN_BIT] && !cur_ff.ctrlEn && cur_ff.lockHit) begin
				n.skipNext = 1'b1; // [RQ13]
				n.lockHit = 1'b0;
			end
		end

		case (cur_ff.st)
			dcm_pkg::S_IDLE: begin
				if (snpValid && !cur_ff.snpDone) begin
					if (snoopControl == dcm_pkg::SNP_KEEP_SINK ||
						snoopControl == dcm_pkg::SNP_INVALID) begin // [RQ25]
						n.st = dcm_pkg::S_SNP_LOOK;
					end else begin
						n.snpDone = 1'b1; // [RQ23] [RQ14]
					end
				end else if (cpuReq && !cur_ff.cpuAck) begin
					n.st = dcm_pkg::S_CPU_LOOK;
				end
			end

			dcm_pkg::S_SNP_LOOK: begin
				hit = rdEnt.valid && rdEnt.tag == snpAddr[31:dcm_pkg::IDX_W+4];
				n.snpDone = 1'b1;
				n.st = dcm_pkg::S_IDLE;
				n.arrIdx = snpAddr[dcm_pkg::IDX_W+3:4];
				n.arrWdata = rdEnt;
				n.arrWdata.valid = 1'b0;
				n.arrWdata.dirty = 4'h0;
				if (hit && !snpWr) begin // [RQ14]
					if (dirty) begin
						n.snpInh = 1'b1; // [RQ16]
						n.snpRdata = rdEnt.data;
					end
					n.arrWe = snoopControl == dcm_pkg::SNP_INVALID; // [RQ17]
				end else if (hit) begin
					if (snoopControl == dcm_pkg::SNP_INVALID || snpLine || !dirty) begin
						n.arrWe = 1'b1; // [RQ20]
					end else begin
						e.data[{snpAddr[3:2], 5'h00} +: 32] = snpWdata; // [RQ21]
						e.dirty[snpAddr[3:2]] = 1'b1;
						n.arrWdata = e;
						n.arrWe = 1'b1;
						n.snpInh = 1'b1;
					end
				end
			end

			dcm_pkg::S_CPU_LOOK: begin
				hit = rdEnt.valid && rdEnt.tag == cpuAddr[31:dcm_pkg::IDX_W+4];
				inh = cachingModeField == dcm_pkg::MODE_NS ||
					cachingModeField == dcm_pkg::MODE_SER; // [RQ26]
				n.arrIdx = cpuAddr[dcm_pkg::IDX_W+3:4];
				n.arrWdata = rdEnt;
				n.arrWdata.valid = 1'b0;
				n.arrWdata.dirty = 4'h0;
				n.singleAfter = 1'b0;
				n.st = dcm_pkg::S_SINGLE;
				if (inh) begin
					if (hit && dirty) begin
						n.cbData = rdEnt.data; // [RQ8] [RQ4]
						n.cbAddr = {rdEnt.tag, n.arrIdx, 4'h0};
						n.arrWe = 1'b1;
						n.singleAfter = 1'b1;
						n.st = dcm_pkg::S_PUSH;
					end else if (hit) begin
						n.arrWe = 1'b1; // [RQ8]
					end
				end else if (!cur_ff.ctrlEn) begin
					if (cpuLocked && hit) begin
						n.lockHit = 1'b1; // [RQ13]
					end
				end else if (hit) begin
					if (!cpuWr) begin
						n.cpuRdata = rdEnt.data[{w, 5'h00} +: 32]; // [RQ15]
						n.cpuAck = 1'b1;
						n.st = dcm_pkg::S_IDLE;
					end else if (cpuBlockMove) begin
						n.arrWe = 1'b1; // [RQ12]
					end else if (cachingModeField == dcm_pkg::MODE_WT) begin
						e.data[{w, 5'h00} +: 32] = cpuWdata; // [RQ19] [RQ1]
						n.arrWdata = e;
						n.arrWe = 1'b1;
					end else begin
						e.data[{w, 5'h00} +: 32] = cpuWdata; // [RQ3]
						e.dirty[w] = 1'b1;
						n.arrWdata = e;
						n.arrWe = 1'b1;
						n.cpuAck = 1'b1;
						n.st = dcm_pkg::S_IDLE;
					end
				end else begin
					noAlloc = cpuNoAlloc || cpuBlockMove ||
						(cur_ff.skipNext && !cpuLocked); // [RQ11] [RQ12] [RQ13]
					if (!cpuLocked) begin
						n.skipNext = 1'b0;
					end
					if (!noAlloc && !(cpuWr && cachingModeField == dcm_pkg::MODE_WT)) begin
						if (rdEnt.valid && dirty) begin
							n.cbData = rdEnt.data; // [RQ6]
							n.cbAddr = {rdEnt.tag, n.arrIdx, 4'h0};
							n.pushPend = 1'b1;
						end
						n.st = dcm_pkg::S_FILL; // [RQ2] [RQ5]
					end
				end
			end

			// one long-word transfer, performed exactly once per request
			dcm_pkg::S_SINGLE: begin
				if (!cur_ff.busReq) begin
					n.busReq = 1'b1; // [RQ9] [RQ10]
					n.busLine = 1'b0;
					n.busWr = cpuWr;
					n.busAddr = {cpuAddr[31:2], 2'h0};
					n.busWdata = cpuWdata;
					n.busCi = cachingModeField == dcm_pkg::MODE_NS ||
						cachingModeField == dcm_pkg::MODE_SER; // [RQ7]
				end else if (busAck) begin
					n.busReq = 1'b0;
					n.busWr = 1'b0;
					n.busCi = 1'b0;
					n.cpuRdata = busRdata;
					n.cpuAck = 1'b1;
					n.st = dcm_pkg::S_IDLE;
				end
			end

			dcm_pkg::S_FILL: begin
				if (!cur_ff.busReq) begin
					n.busReq = 1'b1; // [RQ2]
					n.busLine = 1'b1;
					n.busWr = 1'b0;
					n.busCi = 1'b0;
					n.busAddr = {cpuAddr[31:4], 4'h0};
					n.beat = 2'h0;
				end else if (busAck) begin
					fd[{cur_ff.beat, 5'h00} +: 32] = busRdata;
					n.fillData = fd;
					n.beat = cur_ff.beat + 2'h1;
					n.busAddr = cur_ff.busAddr + 32'h4;
					if (cur_ff.beat == dcm_pkg::LAST_BEAT) begin
						e.valid = 1'b1;
						e.dirty = 4'h0;
						e.tag = cpuAddr[31:dcm_pkg::IDX_W+4];
						e.data = fd;
						if (cpuWr) begin
							e.data[{w, 5'h00} +: 32] = cpuWdata; // [RQ5]
							e.dirty[w] = 1'b1;
						end
						n.arrIdx = cpuAddr[dcm_pkg::IDX_W+3:4];
						n.arrWdata = e;
						n.arrWe = 1'b1;
						n.cpuRdata = fd[{w, 5'h00} +: 32];
						n.cpuAck = 1'b1;
						n.busReq = 1'b0;
						n.busLine = 1'b0;
						n.st = cur_ff.pushPend ? dcm_pkg::S_PUSH : dcm_pkg::S_IDLE; // [RQ6]
					end
				end
			end

			// copyback buffer written out as one line write
			dcm_pkg::S_PUSH: begin
				if (!cur_ff.busReq) begin
					n.busReq = 1'b1; // [RQ4]
					n.busLine = 1'b1;
					n.busWr = 1'b1;
					n.busCi = 1'b0;
					n.busAddr = cur_ff.cbAddr;
					n.busWdata = cur_ff.cbData[31:0];
					n.beat = 2'h0;
				end else if (busAck) begin
					n.beat = cur_ff.beat + 2'h1;
					n.busAddr = cur_ff.busAddr + 32'h4;
					n.busWdata = cur_ff.cbData[{n.beat, 5'h00} +: 32];
					if (cur_ff.beat == dcm_pkg::LAST_BEAT) begin
						n.busReq = 1'b0;
						n.busLine = 1'b0;
						n.busWr = 1'b0;
						n.pushPend = 1'b0;
						n.st = cur_ff.singleAfter ? dcm_pkg::S_SINGLE : dcm_pkg::S_IDLE;
					end
				end
			end

			default: begin
				n.st = dcm_pkg::S_IDLE;
			end
		endcase
		nxt_st = n;
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_st;
		end
	end

	assign prdata = cur_ff.prdata;
	assign pready = cur_ff.pready;
	assign pslverr = cur_ff.pslverr;
	assign cpuAck = cur_ff.cpuAck;
	assign cpuRdata = cur_ff.cpuRdata;
	assign busReq = cur_ff.busReq;
	assign busWr = cur_ff.busWr;
	assign busLine = cur_ff.busLine;
	assign busAddr = cur_ff.busAddr;
	assign busWdata = cur_ff.busWdata;
	assign cacheInhibitOut = cur_ff.busCi;
	assign snpDone = cur_ff.snpDone;
	assign snpInhibitMem = cur_ff.snpInh;
	assign snpRdata = cur_ff.snpRdata;

endmodule : dcm_cache_ctrl

// *** dv/dcm_cache_checker.sv ***
// Purpose: port-level checks on the cache controller
// Assumes: bound to dcm_cache_ctrl, single clock domain
// Notes: a helper counter tracks the beats of the current bus transfer
`timescale 1ns/1ps
module dcm_cache_checker (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// processor and memory bus
	input wire logic cpuAck,
	input wire logic busReq,
	input wire logic busLine,
	input wire logic [31:0] busAddr,
	input wire logic busAck,
	input wire logic cacheInhibitOut,
	// snoop
	input wire logic snpDone,
	input wire logic snpInhibitMem,
	input wire logic [1:0] snoopControl
);
	default clocking dcmCb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	logic [2:0] beatCnt_ff;
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			beatCnt_ff <= 3'h0;
		end else if (!busReq) begin
			beatCnt_ff <= 3'h0;
		end else if (busAck) begin
			beatCnt_ff <= beatCnt_ff + 3'h1;
		end
	end
	sequence lineAck;
		busReq && busAck && busLine;
	endsequence
	sequence inhAck;
		cacheInhibitOut && busAck;
	endsequence
	chk_line_four: assert property (lineAck |=> busReq == (beatCnt_ff != 3'h4))
		else $error("line transfer did not end after four beats");
	chk_line_step: assert property (lineAck |=> !busReq || busAddr == $past(busAddr) + 32'h4)
		else $error("line beat address did not advance by four");
	chk_line_base: assert property ($rose(busReq) && busLine |-> busAddr[3:0] == 4'h0)
		else $error("line transfer not started at line base");
	chk_inh_single: assert property (cacheInhibitOut |-> busReq && !busLine)
		else $error("inhibit out outside a single transfer");
	chk_inh_end: assert property (inhAck |=> !cacheInhibitOut && !busReq && cpuAck)
		else $error("inhibited transfer did not complete to the processor");
	chk_req_hold: assert property (busReq && !busAck |=> busReq && $stable(busAddr))
		else $error("bus request dropped or moved before ack");
	chk_ack_once: assert property (cpuAck |=> !cpuAck)
		else $error("processor ack longer than one cycle");
	chk_inh_codes: assert property (snpInhibitMem |-> snpDone &&
		(snoopControl == dcm_pkg::SNP_KEEP_SINK || snoopControl == dcm_pkg::SNP_INVALID))
		else $error("memory inhibited for a non-snooping code");
endmodule : dcm_cache_checker

bind dcm_cache_ctrl dcm_cache_checker u_chk (.sys_clk(sys_clk), .rstn(rstn), .cpuAck(cpuAck),
	.busReq(busReq), .busLine(busLine), .busAddr(busAddr), .busAck(busAck),
	.cacheInhibitOut(cacheInhibitOut), .snpDone(snpDone), .snpInhibitMem(snpInhibitMem),
	.snoopControl(snoopControl));

// *** dv/dcm_mem_model.sv ***
// Purpose: external memory answering the controller one beat per ack
// Assumes: request held until ack; slow adds three wait cycles before the first beat, two before each later beat
// Notes: unwritten words read back as an address pattern
`timescale 1ns/1ps
module dcm_mem_model (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// pacing
	input wire logic slow,
	// memory bus
	input wire logic busReq,
	input wire logic busWr,
	input wire logic [31:0] busAddr,
	input wire logic [31:0] busWdata,
	output logic busAck,
	output logic [31:0] busRdata
);
	logic [31:0] mem [logic [31:0]];
	logic [1:0] waitCnt;
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			busAck <= 1'b0;
			busRdata <= 32'h0;
			waitCnt <= 2'h0;
		end else if (busReq && !busAck && (waitCnt == 2'h3 || !slow)) begin
			busAck <= 1'b1;
			waitCnt <= 2'h0;
			busRdata <= mem.exists(busAddr) ? mem[busAddr] : {busAddr[15:0], ~busAddr[15:0]};
			if (busWr) mem[busAddr] = busWdata;
		end else begin
			// released data toggles each cycle, so it matches the last beat every second cycle
			busAck <= 1'b0;
			busRdata <= ~busRdata;
			waitCnt <= busReq ? waitCnt + 2'h1 : 2'h0;
		end
	end
endmodule : dcm_mem_model

// *** dv/tb.sv ***
// Purpose: self-checking bench for the cache controller
// Assumes: array contents unknown after reset, so sets 1 to 8 used by the rows and final runs are filled first
// Notes: row cnt nibbles are line reads, line writes, single beats, inhibited beats
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin totalChecks++; if ((got) !== (ex)) begin badCount++; \
	$display("wrong value %s expected %h seen %h", nm, ex, got); end end
module tb;
	logic sys_clk = 1'b0, rstn = 1'b0, slow = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata;
	logic cpuReq = 1'b0, cpuWr = 1'b0, cpuNoAlloc = 1'b0, cpuBlockMove = 1'b0, cpuLocked = 1'b0;
	logic [1:0] cachingModeField = 2'h0, snoopControl = 2'h0;
	logic [31:0] cpuAddr = 32'h0, cpuWdata = 32'h0, cpuRdata, busAddr, busWdata, busRdata;
	logic cpuAck, busReq, busWr, busLine, cacheInhibitOut, busAck, snpDone, snpInhibitMem;
	logic snpValid = 1'b0, snpWr = 1'b0, snpLine = 1'b0;
	logic [31:0] snpAddr = 32'h0, snpWdata = 32'h0, rd;
	logic [127:0] snpRdata;
	logic [15:0] seen;
	logic [91:0] rows [21];
	logic er;
	int badCount = 0, totalChecks = 0, cycles = 0;
	dcm_cache_ctrl dut (.*);
	dcm_mem_model mem (.*);
	initial forever #4 sys_clk = ~sys_clk;
	function automatic logic [31:0] pat(input logic [31:0] a);
		return {a[15:0], ~a[15:0]};
	endfunction : pat
	always @(negedge sys_clk) begin
		if (busReq && busAck && busLine) begin
			if (busWr) seen[11:8] += 4'h1;
			else seen[15:12] += 4'h1;
		end else if (busReq && busAck) begin
			seen[7:4] += 4'h1;
			if (cacheInhibitOut) seen[3:0] += 4'h1;
		end
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 30000) begin
			badCount++;
			endSim();
		end
	end
	task automatic endSim();
		$display("checks %0d mismatches %0d", totalChecks, badCount);
		if (badCount == 0 && totalChecks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : endSim
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		// request holds until the rising edge that samples pready high
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask : apb
	// c digits: write, caching mode, {locked, no-allocate, block move}
	task automatic run(input logic [11:0] c, input logic [31:0] a, input logic [31:0] d,
		input logic [15:0] n);
		seen = 16'h0;
		cpuReq <= 1'b1;
		cpuWr <= c[8];
		cachingModeField <= c[5:4];
		{cpuLocked, cpuNoAlloc, cpuBlockMove} <= c[2:0];
		cpuAddr <= a;
		cpuWdata <= d;
		do @(posedge sys_clk); while (cpuAck !== 1'b1);
		cpuReq <= 1'b0;
		repeat (2) @(posedge sys_clk);
		while (busReq !== 1'b0) @(posedge sys_clk);
		@(posedge sys_clk);
		`CHK("busBeats", n, seen)
		if (!c[8]) `CHK("cpuRdata", (d != 32'h0) ? d : pat(a), cpuRdata)
	endtask : run
	// k digit: write, line, snoop code
	task automatic snp(input logic [3:0] k, input logic [31:0] a, input logic [31:0] d,
		input logic ex);
		snpValid <= 1'b1;
		{snpWr, snpLine, snoopControl} <= k;
		snpAddr <= a;
		snpWdata <= d;
		do @(posedge sys_clk); while (snpDone !== 1'b1);
		`CHK("snpInhibitMem", ex, snpInhibitMem)
		snpValid <= 1'b0;
		snpWdata <= ~d;
		@(posedge sys_clk);
	endtask : snp
	initial begin
		rows = '{{12'h000, 32'h1010, 32'h0, 16'h4000},
			{12'h000, 32'h1014, 32'h0, 16'h0000},
			{12'h100, 32'h1018, 32'h11111111, 16'h0010}, {12'h000, 32'h1018, 32'h11111111, 16'h0},
			{12'h100, 32'h1020, 32'h22222222, 16'h0010}, {12'h000, 32'h1020, 32'h22222222, 16'h4000},
			{12'h110, 32'h1010, 32'h33333333, 16'h0000},
			{12'h010, 32'h2010, 32'h0, 16'h4400}, {12'h010, 32'h1010, 32'h33333333, 16'h4000},
			{12'h110, 32'h1030, 32'h44444444, 16'h4000},
			{12'h020, 32'h1030, 32'h44444444, 16'h0411}, {12'h010, 32'h1030, 32'h44444444, 16'h4000},
			{12'h002, 32'h1040, 32'h0, 16'h0010}, {12'h000, 32'h1040, 32'h0, 16'h4000},
			{12'h001, 32'h1044, 32'h0, 16'h0000}, {12'h101, 32'h1048, 32'h55555555, 16'h0010},
			{12'h000, 32'h1040, 32'h0, 16'h4000}, {12'h001, 32'h1050, 32'h0, 16'h0010},
			{12'h130, 32'h1060, 32'h66666666, 16'h0011}, {12'h030, 32'h1060, 32'h66666666, 16'h0011},
			{12'h110, 32'h1070, 32'h77777777, 16'h4000}};
		repeat (2) @(posedge sys_clk);
		rstn <= 1'b1;
		@(posedge sys_clk);
		apb(1'b0, dcm_pkg::CTRL_OFF, 32'h0);
		`CHK("ctrlReset", {31'h0, dcm_pkg::CTRL_EN_RST}, rd)
		apb(1'b1, dcm_pkg::CTRL_OFF, 32'h1);
		apb(1'b0, dcm_pkg::CTRL_OFF, 32'h0);
		`CHK("ctrlEnable", 32'h1, rd)
		apb(1'b0, 12'h008, 32'h0);
		`CHK("unmappedErr", 1'b1, er)
		for (int j = 1; j < 9; j++) run(12'h000, 32'h3000 + 32'(j * 16), 32'h0, 16'h4000);
		foreach (rows[i]) begin
			slow <= i[0];
			run(rows[i][91:80], rows[i][79:48], rows[i][47:16], rows[i][15:0]);
		end
		snp(4'h0, 32'h1070, 32'h0, 1'b0);
		snp(4'h3, 32'h1070, 32'h0, 1'b0);
		snp(4'h5, 32'h1070, 32'h0, 1'b1);
		`CHK("snpRdata", 32'h77777777, snpRdata[31:0])
		run(12'h010, 32'h1070, 32'h77777777, 16'h0);
		snp(4'h5, 32'h5070, 32'h0, 1'b0);
		snp(4'h9, 32'h1074, 32'h88888888, 1'b1);
		run(12'h010, 32'h1074, 32'h88888888, 16'h0);
		snp(4'h6, 32'h1070, 32'h0, 1'b1);
		run(12'h010, 32'h1070, 32'h0, 16'h4000);
		snp(4'hD, 32'h1070, 32'h99999999, 1'b0);
		run(12'h010, 32'h1070, 32'h0, 16'h4000);
		apb(1'b1, dcm_pkg::CTRL_OFF, 32'h0);
		run(12'h004, 32'h1010, 32'h33333333, 16'h0010);
		apb(1'b1, dcm_pkg::CTRL_OFF, 32'h1);
		apb(1'b0, dcm_pkg::STAT_OFF, 32'h0);
		`CHK("skipNext", 32'h2, rd)
		run(12'h000, 32'h1080, 32'h0, 16'h0010);
		run(12'h000, 32'h1080, 32'h0, 16'h4000);
		endSim();
	end
endmodule : tb
